// ==== pkg/hci_params.svh ====
// offsets, field positions, reset values and timing counts of the hub interlock block
`ifndef HCI_PARAMS_SVH
`define HCI_PARAMS_SVH

// ==========================================================
// register offsets
`define HCI_OFS_OVER_CURRENT   8'he6
`define HCI_OFS_INTERLOCK      8'he7

// ==========================================================
// field positions and reset values
`define HCI_OVC_LSB            1
`define HCI_OVC_MSB            3
`define HCI_ILOCK_CONFIG_BIT   0
`define HCI_ILOCK_CONNECT_BIT  1
`define HCI_OVC_RESET          8'h00
`define HCI_PWR_RESET          8'h00
`define HCI_ILOCK_RESET        8'h00

// ==========================================================
// timing: clock rate and configuration timeout
`define HCI_CLK_MHZ            25
`define HCI_T_CONFIG_US        1000
`define HCI_CONFIG_CYCLES      (`HCI_T_CONFIG_US * `HCI_CLK_MHZ)

`endif

// ==== pkg/hci_pkg.sv ====
// types of the hub interlock block
`default_nettype none
package hci_pkg;
	// start-up stages of the hub
	typedef enum logic [1:0] {
		HCI_ST_CONFIG,
		HCI_ST_CHGDET,
		HCI_ST_CONNECT,
		HCI_ST_COMM
	} hci_stage_t;
endpackage : hci_pkg
`default_nettype wire

// ==== verilog/hci_timer.sv ====
// down counter that signals the end of the configuration timeout
`timescale 1ns/1ps
`default_nettype none
module hci_timer #(
	parameter int CYCLES = 25000
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic run,
	output var  logic expired
);
	localparam int W = $clog2(CYCLES + 1);

	// elaboration check: a zero-length timeout cannot be counted
	if (CYCLES < 1) begin : g_bad_cycles
		$error("hci_timer: CYCLES must be at least one");
	end

	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         expired_next;

	// ==========================================================
	// count while run is high; holding run low restarts the count
	always_comb begin
		cnt_next     = cnt_reg;
		expired_next = 1'b0;
		if (!run) begin
			cnt_next = W'(CYCLES - 1);
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - W'(1);
		end else begin
			expired_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_reg <= W'(CYCLES - 1);
			expired <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			expired <= expired_next;
		end
	end
endmodule : hci_timer
`default_nettype wire

// ==== verilog/hci_regbank.sv ====
// over-current and serial interlock registers with the hub start-up stage sequencer
`include "hci_params.svh"
`timescale 1ns/1ps
`default_nettype none
module hci_regbank #(
	parameter int CONFIG_CYCLES = `HCI_CONFIG_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output var  logic [7:0] reg_rdata,
	output var  logic       reg_rvalid,
	input  wire logic       attach_proceed,
	input  wire logic       chgdet_done,
	input  wire logic [3:1] host_power_on,
	output var  logic [3:1] over_current_sense,
	output var  logic [3:1] port_power_status,
	output var  logic       stage_config,
	output var  logic       stage_chgdet,
	output var  logic       stage_connect,
	output var  logic       attach_en
);
	// ==========================================================
	// elaboration check: the timer cannot serve a timeout shorter than one cycle
	if (CONFIG_CYCLES < 1) begin : g_bad_cycles
		$error("hci_regbank: CONFIG_CYCLES must be at least one");
	end

	// reset values cut down to the fields that are really stored
	localparam logic [3:1] OVC_RESET      = 3'(`HCI_OVC_RESET >> `HCI_OVC_LSB);
	localparam logic [3:1] PWR_RESET      = 3'(`HCI_PWR_RESET >> `HCI_OVC_LSB);
	localparam logic       CFG_HOLD_RESET = 1'(`HCI_ILOCK_RESET >> `HCI_ILOCK_CONFIG_BIT);
	localparam logic       CON_HOLD_RESET = 1'(`HCI_ILOCK_RESET >> `HCI_ILOCK_CONNECT_BIT);

	// ==========================================================
	// address decode
	logic wr_ovc;
	logic wr_ilock;
	logic ilock_release;
	logic timeout;

	assign wr_ovc        = reg_wr && (reg_addr == `HCI_OFS_OVER_CURRENT);
	assign wr_ilock      = reg_wr && (reg_addr == `HCI_OFS_INTERLOCK);
	// any interlock write leaving config hold low releases the config stage
	assign ilock_release = wr_ilock && !reg_wdata[`HCI_ILOCK_CONFIG_BIT];

	// ==========================================================
	// register state
	logic [3:1] ovc_next;
	logic       cfg_hold_reg;
	logic       cfg_hold_next;
	logic       con_hold_reg;
	logic       con_hold_next;
	logic       wrote_ilock_reg;
	logic       wrote_ilock_next;
	logic [3:1] pwr_next;
	logic [7:0] rdata_next;
	logic       rvalid_next;

	// register writes; upper over-current bits are never stored, so a stray one is harmless
	always_comb begin
		ovc_next         = over_current_sense;
		cfg_hold_next    = cfg_hold_reg;
		con_hold_next    = con_hold_reg;
		wrote_ilock_next = wrote_ilock_reg || wr_ilock;
		if (wr_ovc) begin
			ovc_next = reg_wdata[`HCI_OVC_MSB:`HCI_OVC_LSB];
		end
		if (wr_ilock) begin
			cfg_hold_next = reg_wdata[`HCI_ILOCK_CONFIG_BIT];
			con_hold_next = reg_wdata[`HCI_ILOCK_CONNECT_BIT];
		end
	end

	// port power status: host enable sets, over-current clears and wins
	always_comb begin
		pwr_next = (port_power_status | host_power_on) & ~ovc_next;
	end

	// read path, registered; unmapped offsets answer zero
	always_comb begin
		rdata_next  = 8'h00;
		rvalid_next = reg_rd;
		if (reg_rd) begin
			unique case (reg_addr)
				`HCI_OFS_OVER_CURRENT: rdata_next = {4'h0, over_current_sense, 1'b0};
				`HCI_OFS_INTERLOCK:    rdata_next = {6'h00, con_hold_reg, cfg_hold_reg};
				default:               rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			over_current_sense <= OVC_RESET;
			cfg_hold_reg       <= CFG_HOLD_RESET;
			con_hold_reg       <= CON_HOLD_RESET;
			wrote_ilock_reg    <= 1'b0;
			port_power_status  <= PWR_RESET;
			reg_rdata          <= 8'h00;
			reg_rvalid         <= 1'b0;
		end else begin
			over_current_sense <= ovc_next;
			cfg_hold_reg       <= cfg_hold_next;
			con_hold_reg       <= con_hold_next;
			wrote_ilock_reg    <= wrote_ilock_next;
			port_power_status  <= pwr_next;
			reg_rdata          <= rdata_next;
			reg_rvalid         <= rvalid_next;
		end
	end

	// ==========================================================
	// configuration timeout, running only while nothing has touched the interlock
	logic stage_is_cfg;

	hci_timer #(
		.CYCLES (CONFIG_CYCLES)
	) u_timer (
		.clk     (clk),
		.resetn  (resetn),
		.run     (stage_is_cfg && !wrote_ilock_reg && !wr_ilock),
		.expired (timeout)
	);

	// ==========================================================
	// start-up stage sequencer
	hci_pkg::hci_stage_t stage_reg;
	hci_pkg::hci_stage_t stage_next;
	logic                stage_config_next;
	logic                stage_chgdet_next;
	logic                stage_connect_next;
	logic                attach_en_next;

	assign stage_is_cfg = (stage_reg == hci_pkg::HCI_ST_CONFIG);

	// config leaves on a releasing write or on timeout; connect waits for bit and pin
	always_comb begin
		stage_next = stage_reg;
		unique case (stage_reg)
			hci_pkg::HCI_ST_CONFIG: begin
				if (ilock_release) begin
					stage_next = hci_pkg::HCI_ST_CHGDET;
				end else if (timeout && !cfg_hold_reg && !wrote_ilock_reg) begin
					stage_next = hci_pkg::HCI_ST_CHGDET;
				end
			end
			hci_pkg::HCI_ST_CHGDET: begin
				if (chgdet_done) begin
					stage_next = hci_pkg::HCI_ST_CONNECT;
				end
			end
			hci_pkg::HCI_ST_CONNECT: begin
				if (!con_hold_reg && attach_proceed) begin
					stage_next = hci_pkg::HCI_ST_COMM;
				end
			end
			hci_pkg::HCI_ST_COMM: begin
				stage_next = hci_pkg::HCI_ST_COMM;
			end
		endcase
	end

	// one-hot flags decoded from the next stage, so they change on the same edge as stage_reg
	always_comb begin
		stage_config_next  = (stage_next == hci_pkg::HCI_ST_CONFIG);
		stage_chgdet_next  = (stage_next == hci_pkg::HCI_ST_CHGDET);
		stage_connect_next = (stage_next == hci_pkg::HCI_ST_CONNECT);
		attach_en_next     = (stage_next == hci_pkg::HCI_ST_COMM);
	end

	// stage flags come from flops so the hub core sees clean levels
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage_reg     <= hci_pkg::HCI_ST_CONFIG;
			stage_config  <= 1'b1;
			stage_chgdet  <= 1'b0;
			stage_connect <= 1'b0;
			attach_en     <= 1'b0;
		end else begin
			stage_reg     <= stage_next;
			stage_config  <= stage_config_next;
			stage_chgdet  <= stage_chgdet_next;
			stage_connect <= stage_connect_next;
			attach_en     <= attach_en_next;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_ovc_follows_write: assert property (
		wr_ovc |=> over_current_sense[3] == $past(reg_wdata[3]))
		else $error("port 3 over-current flag did not take the written value");

	a_ovc_low_ports: assert property (
		wr_ovc |=> over_current_sense[2:1] == $past(reg_wdata[2:1]))
		else $error("port 2/1 over-current flags did not take the written value");

	a_ovc_kills_pwr: assert property (
		##1 ((over_current_sense & port_power_status) == 3'b000))
		else $error("power status still set on a port with over-current");

	a_pwr_set_host: assert property (
		(host_power_on[1] && !ovc_next[1]) |=> port_power_status[1])
		else $error("host power enable did not set port power status");

	a_connect_held: assert property (
		(stage_connect && con_hold_reg) |=> !attach_en)
		else $error("hub attached while connect hold set");

	a_connect_go: assert property (
		(stage_reg == hci_pkg::HCI_ST_CONNECT && !con_hold_reg && attach_proceed) |=> ##[0:1] attach_en)
		else $error("connect stage did not advance with hold clear");

	a_pin_gates: assert property (
		(stage_reg == hci_pkg::HCI_ST_CONNECT && !attach_proceed) |=> stage_reg != hci_pkg::HCI_ST_COMM)
		else $error("connect stage advanced without attach-proceed");

	a_config_held: assert property (
		(stage_is_cfg && cfg_hold_reg && !ilock_release) |=> stage_is_cfg)
		else $error("config stage left while config hold set");

	a_release_now: assert property (
		(stage_is_cfg && ilock_release) |=> (stage_reg == hci_pkg::HCI_ST_CHGDET && stage_chgdet))
		else $error("config stage not left at once on release write");

	a_timeout_only: assert property (
		(stage_is_cfg && !ilock_release && !timeout) |=> stage_is_cfg)
		else $error("config stage left without timeout or release");

	a_reserved_zero: assert property (
		(reg_rd && reg_addr == `HCI_OFS_INTERLOCK) |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
		else $error("interlock reserved bits read nonzero");

	a_ovc_readback: assert property (
		(reg_rd && reg_addr == `HCI_OFS_OVER_CURRENT) |=> reg_rdata == {4'h0, $past(over_current_sense), 1'b0})
		else $error("over-current read did not return the stored flags");

	a_ilock_readback: assert property (
		(reg_rd && reg_addr == `HCI_OFS_INTERLOCK) |=> reg_rdata[1:0] == {$past(con_hold_reg), $past(cfg_hold_reg)})
		else $error("interlock read did not return the hold bits");

	a_unmapped_zero: assert property (
		(reg_rd && reg_addr != `HCI_OFS_OVER_CURRENT && reg_addr != `HCI_OFS_INTERLOCK) |=> reg_rdata == 8'h00)
		else $error("unmapped offset read nonzero");

	a_rvalid_answer: assert property (
		reg_rd |=> reg_rvalid)
		else $error("read got no answer pulse");

	a_rvalid_quiet: assert property (
		!reg_rd |=> !reg_rvalid)
		else $error("answer pulse without a read");

	a_hold_write: assert property (
		(wr_ilock && reg_wdata[`HCI_ILOCK_CONFIG_BIT]) |=> cfg_hold_reg)
		else $error("config hold not taken from interlock write");

	a_timeout_exit: assert property (
		(stage_is_cfg && timeout && !cfg_hold_reg && !wrote_ilock_reg) |=> stage_chgdet)
		else $error("config stage not left at timeout");

	a_comm_stays: assert property (
		attach_en |=> attach_en)
		else $error("communication stage left before reset");

	a_pwr_kept: assert property (
		(port_power_status[3] && !ovc_next[3]) |=> port_power_status[3])
		else $error("port 3 power status dropped without over-current");

	c_release_write: cover property (stage_is_cfg && ilock_release);
	c_timeout_exit: cover property (stage_is_cfg && timeout);
	c_attach: cover property (!attach_en ##1 attach_en);
	c_ovc_trip: cover property (port_power_status[3] && ovc_next[3]);
endmodule : hci_regbank
`default_nettype wire

// ==== testbench/hci_master.sv ====
// register master model that configures the hub through its register port
`timescale 1ns/1ps
`default_nettype none
module hci_master (
	input  wire logic       clk,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// ==========================================================
	// idle bus
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// ==========================================================
	// one-cycle write; released lines show the inverse, not the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = (a == 8'he6) ? (d & 8'h0f) : d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask : wr

	// config hold set first, released after the over-current writes
	task automatic hold_cfg();
		wr(8'he7, 8'h01);
	endtask : hold_cfg

	task automatic release_cfg(input logic [7:0] d);
		wr(8'he7, d & 8'hfe);
	endtask : release_cfg

	// read; a missing answer comes back unknown so it cannot match
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		int n;
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		for (n = 0; n < 3 && reg_rvalid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		q = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask : rd
endmodule : hci_master
`default_nettype wire

// ==== testbench/testbench.sv ====
// self-checking bench of the hub interlock register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int CYC = 8;
	logic       clk, resetn, attach_proceed, chgdet_done, reg_wr, reg_rd, reg_rvalid;
	logic       stage_config, stage_chgdet, stage_connect, attach_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
	logic [3:1] host_power_on, over_current_sense, port_power_status;
	int         bad_count, cmp_count, m_ovc, m_lock, m_pp, m_st, i;

	hci_regbank #(.CONFIG_CYCLES(CYC)) dut_u (.clk(clk), .resetn(resetn), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .attach_proceed(attach_proceed), .chgdet_done(chgdet_done),
		.host_power_on(host_power_on), .over_current_sense(over_current_sense),
		.port_power_status(port_power_status), .stage_config(stage_config),
		.stage_chgdet(stage_chgdet), .stage_connect(stage_connect), .attach_en(attach_en));
	hci_master partner_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic cstage();
		chk("stage", {4'h0, attach_en, stage_connect, stage_chgdet, stage_config}, 8'(1 << m_st));
	endtask : cstage

	task automatic cmp_all();
		chk("over current", {5'h00, over_current_sense}, 8'(m_ovc));
		chk("port power", {5'h00, port_power_status}, 8'(m_pp));
	endtask : cmp_all

	task automatic rst();
		resetn = 1'b0;
		tick(4);
		resetn = 1'b1;
		m_ovc = 0;
		m_lock = 0;
		m_pp = 0;
		m_st = 0;
	endtask : rst

	// writes update the model before the design is compared
	task automatic wo(input logic [7:0] d);
		partner_u.wr(8'he6, d);
		m_ovc = d[3:1];
		m_pp = m_pp & ~m_ovc;
		tick(1);
		cmp_all();
	endtask : wo

	task automatic hp(input logic [3:1] h);
		host_power_on = h;
		tick(1);
		host_power_on = 3'h0;
		m_pp = m_pp | (h & ~m_ovc);
		tick(1);
		cmp_all();
	endtask : hp

	task automatic wl(input logic [7:0] d);
		partner_u.wr(8'he7, d);
		m_lock = d[1:0];
		if (m_st == 0 && !d[0])
			m_st = 1;
		tick(1);
		cstage();
		partner_u.rd(8'he7, q);
		chk("interlock", q, 8'(m_lock));
	endtask : wl

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================
	// clock and watchdog; the run needs well under a thousand cycles
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		#400000;
		bad_count++;
		wrap_up();
	end

	// ==========================================================
	// tests
	initial begin
		{resetn, attach_proceed, chgdet_done, host_power_on} = '0;
		bad_count = 0;
		cmp_count = 0;
		void'($urandom(79259));
		rst();
		tick(CYC);
		cstage();
		tick(1);
		m_st = 1;
		cstage();
		partner_u.rd(8'he6, q);
		chk("over current reset", q, 8'h00);
		partner_u.rd(8'he5, q);
		chk("unmapped", q, 8'h00);
		$display("test timeout done");
		rst();
		partner_u.hold_cfg();
		m_lock = 1;
		tick(CYC * 3);
		cstage();
		partner_u.rd(8'he7, q);
		chk("hold read", q, 8'h01);
		wo(8'h08);
		hp(3'h7);
		wo(8'hff);
		partner_u.rd(8'he6, q);
		chk("over current read", q, 8'h0e);
		for (i = 0; i < 6; i++) begin
			wo(8'($urandom));
			hp(3'($urandom));
		end
		partner_u.release_cfg(8'hff);
		wl(8'hfe);
		$display("test config hold done");
		chgdet_done = 1'b1;
		attach_proceed = 1'b1;
		m_st = 2;
		tick(24);
		cstage();
		attach_proceed = 1'b0;
		wl(8'h00);
		tick(6);
		cstage();
		attach_proceed = 1'b1;
		m_st = 3;
		tick(3);
		cstage();
		$display("test connect done");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
